// ==== rtl/msrb_pkg.sv ====
// Package for the model-specific register bank: register indices,
// field positions and reset values shared by the bank and its testbench.
// Assumes a single 64-bit core datapath on one clock.
package msrb_pkg;
    // ************************************************************
    // Register indices (numeric register address)
    // ************************************************************
    localparam logic [11:0] ADDR_MC_ADDRESS = 12'h000;
    localparam logic [11:0] ADDR_MC_TYPE = 12'h001;
    localparam logic [11:0] ADDR_CYCLE_STAMP = 12'h010;
    localparam logic [11:0] ADDR_PLATFORM_ID = 12'h017;
    localparam logic [11:0] ADDR_INTR_BASE = 12'h01b;
    localparam logic [11:0] ADDR_HARD_POWERON = 12'h02a;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PLAT_LSB = 50;
    localparam int PLAT_MSB = 52;
    localparam int BASE_BOOT_BIT = 8;
    localparam int BASE_EN_BIT = 11;
    localparam int BASE_ADDR_LSB = 12;
    localparam int BASE_ADDR_MSB = 31;
    localparam int HPO_TRISTATE_BIT = 0;
    localparam int HPO_SELFTEST_BIT = 1;
    localparam int HALF = 32;

    // ************************************************************
    // Reset values and counter step
    // ************************************************************
    localparam logic [63:0] ZERO64 = 64'h0;
    localparam logic [19:0] BASE_ADDR_RESET = 20'hfee00;
    localparam logic BASE_EN_RESET = 1'b1;
    localparam logic [63:0] CYCLE_STEP = 64'h1;

    // Answer kinds for an access
    typedef enum logic [1:0] {
        MSRB_ACK_OK = 2'h0,
        MSRB_ACK_BAD = 2'h1
    } msrb_ack_e;
endpackage : msrb_pkg

// ==== rtl/msrb_strap_if.sv ====
// Carrier for captured strap values between the bank and its strap latch.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
`default_nettype none
interface msrb_strap_if;
    logic tristate_en; // Strap captured from the management-interrupt pin
    logic selftest_en; // Strap captured from the initialisation pin
    modport latch (output tristate_en, output selftest_en);
    modport bank (input tristate_en, input selftest_en);
endinterface : msrb_strap_if
`default_nettype wire

// ==== rtl/msrb_strap_latch.sv ====
// Strap capture: synchronises two strap pins and latches them when reset
// is released. Assumes SRST is synchronous to REF_CLK.
`timescale 1ns/10ps
`default_nettype none
module msrb_strap_latch (
    input wire logic clk, // Core clock
    input wire logic srst, // Synchronous reset, high
    input wire logic mgmt_strap_n, // Management-interrupt strap, low active
    input wire logic init_pin_n, // Initialisation strap, low active
    msrb_strap_if.latch straps // Captured values
);
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic srst_q;

    // Two-stage synchroniser; the first stage is read only by the second
    always_ff @(posedge clk) begin
        sync1 <= {init_pin_n, mgmt_strap_n};
        sync2 <= sync1;
        srst_q <= srst;
    end

    // capture on release
    // Asserted (low) pin at the release edge reads as one afterwards
    always_ff @(posedge clk) begin
        if (srst) begin
            straps.tristate_en <= 1'b0;
            straps.selftest_en <= 1'b0;
        end else if (srst_q) begin
            straps.tristate_en <= ~sync2[0];
            straps.selftest_en <= ~sync2[1];
        end
    end
endmodule : msrb_strap_latch
`default_nettype wire

// ==== rtl/msrb_bank.sv ====
// Model-specific register bank: six 64-bit registers reached by the
// model-register read and write instructions via a numeric address.
// Assumes the core issues one-cycle read/write strobes on REF_CLK.
`timescale 1ns/10ps
`default_nettype none
module msrb_bank (
    input wire logic REF_CLK, // Core clock, 100 MHz
    input wire logic SRST, // Synchronous reset, high
    input wire logic [11:0] MSR_ADDR, // Numeric register address
    input wire logic MSR_RD, // Read instruction strobe
    input wire logic MSR_WR, // Write instruction strobe
    input wire logic [63:0] MSR_WDATA, // Write data
    input wire logic [63:0] MC_ADDR_IN, // Machine-check address capture
    input wire logic [63:0] MC_TYPE_IN, // Machine-check type capture
    input wire logic [2:0] PLAT_FLAG, // Platform flag code
    input wire logic BOOT_PROC_IN, // This core is bootstrap processor
    input wire logic MGMT_STRAP_N, // Management-interrupt strap pin
    input wire logic INIT_PIN_N, // Initialisation strap pin
    output logic [63:0] MSR_RDATA, // Read data
    output logic MSR_ACK, // Access done pulse
    output logic MSR_FAULT, // Unmapped address pulse
    output logic LAPIC_EN, // Local controller global enable
    output logic [19:0] LAPIC_BASE // Local controller base address
);
    // ************************************************************
    // State
    // ************************************************************
    logic [63:0] cycle_count;
    logic [63:0] next_cycle_count;
    logic [63:0] rd_mux;
    logic hit;
    logic base_en;
    logic [19:0] base_addr;
    msrb_strap_if straps ();

    // Strap capture lives in its own small module
    msrb_strap_latch u_strap (
        .clk(REF_CLK),
        .srst(SRST),
        .mgmt_strap_n(MGMT_STRAP_N),
        .init_pin_n(INIT_PIN_N),
        .straps(straps)
    );

    // Address decode, used for both reads and writes
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == msrb_pkg::ADDR_MC_ADDRESS) || (a == msrb_pkg::ADDR_MC_TYPE)
            || (a == msrb_pkg::ADDR_CYCLE_STAMP) || (a == msrb_pkg::ADDR_PLATFORM_ID)
            || (a == msrb_pkg::ADDR_INTR_BASE) || (a == msrb_pkg::ADDR_HARD_POWERON);
    endfunction : is_mapped

    assign hit = is_mapped(MSR_ADDR);
    wire wr_stamp = MSR_WR && (MSR_ADDR == msrb_pkg::ADDR_CYCLE_STAMP);
    wire wr_base = MSR_WR && (MSR_ADDR == msrb_pkg::ADDR_INTR_BASE);

    // upper half cleared
    // The counter free-runs; a write replaces it with the zero-extended low half
    assign next_cycle_count = wr_stamp
        ? {32'h0, MSR_WDATA[msrb_pkg::HALF-1:0]}
        : cycle_count + msrb_pkg::CYCLE_STEP;

    // ************************************************************
    // Read selection
    // ************************************************************
    // reserved read zero
    // Every field is placed explicitly so unlisted bits stay zero
    always_comb begin
        rd_mux = msrb_pkg::ZERO64;
        case (MSR_ADDR)
            msrb_pkg::ADDR_MC_ADDRESS: rd_mux = MC_ADDR_IN;
            msrb_pkg::ADDR_MC_TYPE: rd_mux = MC_TYPE_IN;
            msrb_pkg::ADDR_CYCLE_STAMP: rd_mux = cycle_count;
            msrb_pkg::ADDR_PLATFORM_ID: rd_mux[msrb_pkg::PLAT_MSB:msrb_pkg::PLAT_LSB] = PLAT_FLAG;
            msrb_pkg::ADDR_INTR_BASE: begin
                rd_mux[msrb_pkg::BASE_BOOT_BIT] = BOOT_PROC_IN;
                rd_mux[msrb_pkg::BASE_EN_BIT] = base_en;
                rd_mux[msrb_pkg::BASE_ADDR_MSB:msrb_pkg::BASE_ADDR_LSB] = base_addr;
            end
            msrb_pkg::ADDR_HARD_POWERON: begin
                rd_mux[msrb_pkg::HPO_TRISTATE_BIT] = straps.tristate_en;
                rd_mux[msrb_pkg::HPO_SELFTEST_BIT] = straps.selftest_en;
            end
            default: rd_mux = msrb_pkg::ZERO64;
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Time-stamp counter
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cycle_count <= msrb_pkg::ZERO64;
        end else begin
            cycle_count <= next_cycle_count;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            base_en <= msrb_pkg::BASE_EN_RESET;
            base_addr <= msrb_pkg::BASE_ADDR_RESET;
        end else if (wr_base) begin
            base_en <= MSR_WDATA[msrb_pkg::BASE_EN_BIT];
            base_addr <= MSR_WDATA[msrb_pkg::BASE_ADDR_MSB:msrb_pkg::BASE_ADDR_LSB];
        end
    end

    // read-only straps
    // Writes to hard power-on, platform and machine-check regs are ignored
    // Answers registered one cycle after the strobe
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            MSR_RDATA <= msrb_pkg::ZERO64;
            MSR_ACK <= 1'b0;
            MSR_FAULT <= 1'b0;
            LAPIC_EN <= msrb_pkg::BASE_EN_RESET;
            LAPIC_BASE <= msrb_pkg::BASE_ADDR_RESET;
        end else begin
            MSR_RDATA <= (MSR_RD && hit) ? rd_mux : msrb_pkg::ZERO64;
            MSR_ACK <= (MSR_RD || MSR_WR) && hit;
            MSR_FAULT <= (MSR_RD || MSR_WR) && !hit;
            LAPIC_EN <= wr_base ? MSR_WDATA[msrb_pkg::BASE_EN_BIT] : base_en;
            LAPIC_BASE <= wr_base ? MSR_WDATA[msrb_pkg::BASE_ADDR_MSB:msrb_pkg::BASE_ADDR_LSB]
                : base_addr;
        end
    end
endmodule : msrb_bank
`default_nettype wire

// ==== verif/msrb_bank_assertions.sv ====
// Checker for the register bank: answer timing and field relations.
// Assumes one-cycle strobes on REF_CLK and a synchronous high reset.
`timescale 1ns/10ps
`default_nettype none
module msrb_bank_checker (
    input wire logic REF_CLK, // Clock
    input wire logic SRST, // Reset
    input wire logic [11:0] MSR_ADDR, // Address
    input wire logic MSR_RD, // Read
    input wire logic MSR_WR, // Write
    input wire logic [63:0] MSR_WDATA, // Data in
    input wire logic [2:0] PLAT_FLAG, // Code
    input wire logic BOOT_PROC_IN, // Boot flag
    input wire logic [63:0] MSR_RDATA, // Data out
    input wire logic MSR_ACK, // Done
    input wire logic MSR_FAULT, // Unmapped
    input wire logic LAPIC_EN, // Enable
    input wire logic [19:0] LAPIC_BASE // Base
);
    // ************************************************************
    // Decodes and properties
    // ************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    // Access decodes shared by several properties
    wire req = MSR_RD | MSR_WR;
    wire mapped = MSR_ADDR inside {12'h000, 12'h001, 12'h010, 12'h017, 12'h01b, 12'h02a};
    wire base_rd = MSR_RD && MSR_ADDR == 12'h01b;
    wire base_wr = MSR_WR && MSR_ADDR == 12'h01b;
    wire cnt_rd = MSR_RD && MSR_ADDR == 12'h010;
    wire cnt_wr = MSR_WR && MSR_ADDR == 12'h010;
    property p_ack; req && mapped |=> MSR_ACK && !MSR_FAULT; endproperty
    a_ack: assert property (p_ack) else $error("mapped access not acked");
    property p_fault; req && !mapped |=> MSR_FAULT && !MSR_ACK && MSR_RDATA == 64'h0; endproperty
    a_fault: assert property (p_fault) else $error("unmapped access not refused");
    property p_plat; MSR_RD && MSR_ADDR == 12'h017 |=> MSR_RDATA == {11'h0, $past(PLAT_FLAG), 50'h0}; endproperty
    a_plat: assert property (p_plat) else $error("platform code wrong");
    property p_boot;
        base_rd |=> MSR_RDATA[8] == $past(BOOT_PROC_IN) && MSR_RDATA[63:32] == 32'h0;
    endproperty
    a_boot: assert property (p_boot) else $error("boot flag wrong");
    property p_base_wr;
        base_wr |=> LAPIC_EN == $past(MSR_WDATA[11]) && LAPIC_BASE == $past(MSR_WDATA[31:12]);
    endproperty
    a_base_wr: assert property (p_base_wr) else $error("base write lost");
    property p_base_rd; base_rd |=> MSR_RDATA[31:11] == {LAPIC_BASE, LAPIC_EN}; endproperty
    a_base_rd: assert property (p_base_rd) else $error("base readback wrong");
    property p_stamp; cnt_wr ##1 cnt_rd |=> MSR_RDATA == {32'h0, $past(MSR_WDATA[31:0], 2)}; endproperty
    a_stamp: assert property (p_stamp) else $error("counter load wrong");
    // Two reads in a row are one count apart
    property p_count; cnt_rd ##1 cnt_rd |=> MSR_RDATA == $past(MSR_RDATA) + 64'h1; endproperty
    a_count: assert property (p_count) else $error("counter not running");
    property p_hpo; MSR_RD && MSR_ADDR == 12'h02a |=> MSR_RDATA[63:2] == 62'h0; endproperty
    a_hpo: assert property (p_hpo) else $error("power-on reserved bits set");
    c_stamp: cover property (cnt_wr ##1 cnt_rd ##1 cnt_rd);
    c_fault: cover property (req && !mapped);
    c_base: cover property (base_wr ##1 base_rd);
endmodule : msrb_bank_checker
bind msrb_bank msrb_bank_checker u_chk (.REF_CLK(REF_CLK), .SRST(SRST), .MSR_ADDR(MSR_ADDR),
    .MSR_RD(MSR_RD), .MSR_WR(MSR_WR), .MSR_WDATA(MSR_WDATA), .PLAT_FLAG(PLAT_FLAG),
    .BOOT_PROC_IN(BOOT_PROC_IN), .MSR_RDATA(MSR_RDATA), .MSR_ACK(MSR_ACK), .MSR_FAULT(MSR_FAULT),
    .LAPIC_EN(LAPIC_EN), .LAPIC_BASE(LAPIC_BASE));
`default_nettype wire

// ==== verif/test_model_specific_register_bank.sv ====
// Testbench for the register bank: queued expectations, checked on answer.
// Assumes each strobe is answered one cycle later by ACK or FAULT.
`timescale 1ns/10ps
`default_nettype none
module test_model_specific_register_bank;
    // ************************************************************
    // Stimulus and checking
    // ************************************************************
    logic ref_clk = 0, srst = 1, rd = 0, wr = 0, boot = 0, mgmt_n = 0, init_n = 1;
    logic [11:0] addr = 0;
    logic [63:0] wdata = 0, mca = 0, mct = 0, rdata, w;
    logic [2:0] plat = 0;
    logic ack, fault, en;
    logic [19:0] base;
    // Notes are {controller base and enable, fault, data}
    logic [85:0] expq[$];
    logic [85:0] e;
    logic [20:0] lapic_x = {msrb_pkg::BASE_ADDR_RESET, msrb_pkg::BASE_EN_RESET};
    int num_errors = 0, samples_checked = 0, seed = 7956;
    always #5 ref_clk = ~ref_clk;
    msrb_bank u_dut (.REF_CLK(ref_clk), .SRST(srst), .MSR_ADDR(addr), .MSR_RD(rd), .MSR_WR(wr),
        .MSR_WDATA(wdata), .MC_ADDR_IN(mca), .MC_TYPE_IN(mct), .PLAT_FLAG(plat),
        .BOOT_PROC_IN(boot), .MGMT_STRAP_N(mgmt_n), .INIT_PIN_N(init_n), .MSR_RDATA(rdata),
        .MSR_ACK(ack),
        .MSR_FAULT(fault), .LAPIC_EN(en), .LAPIC_BASE(base));
    task chk(input string n, input logic [63:0] x, input logic [63:0] g);
        samples_checked++;
        if (g !== x) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask : chk
    // Raise one strobe and note the answer expected as {fault, data}
    task acc(input logic wn, input logic [11:0] a, input logic [63:0] d, input logic [64:0] x);
        @(posedge ref_clk);
        rd <= !wn;
        wr <= wn;
        addr <= a;
        wdata <= d;
        // base write moves the controller outputs with its answer
        if (wn && a == msrb_pkg::ADDR_INTR_BASE) begin
            lapic_x = {d[31:12], d[11]};
        end
        expq.push_back({lapic_x, x});
    endtask : acc
    task rst;
        @(posedge ref_clk);
        rd <= 0;
        wr <= 0;
        srst <= 1;
        lapic_x = {msrb_pkg::BASE_ADDR_RESET, msrb_pkg::BASE_EN_RESET};
        repeat (20) @(posedge ref_clk);
        srst <= 0;
    endtask : rst
    // Answers are sampled mid-cycle, clear of the launching edge
    always @(negedge ref_clk) begin
        if (ack === 1'b1 || fault === 1'b1) begin
            e = expq.size() > 0 ? expq.pop_front() : {21'h0, 1'b1, 64'hx};
            chk("rdata", e[63:0], rdata);
            chk("fault", {63'h0, e[64]}, {63'h0, fault});
            chk("ack", {63'h0, ~e[64]}, {63'h0, ack});
            chk("intc", {43'h0, e[85:65]}, {43'h0, base, en});
        end
    end
    task test_done;
        chk("pending", 64'h0, 64'(expq.size()));
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        test_done;
    end
    initial begin
        rst;
        w = {$random(seed), $random(seed)};
        acc(0, 12'h01b, 0, {33'h0, msrb_pkg::BASE_ADDR_RESET, msrb_pkg::BASE_EN_RESET, 11'h0});
        acc(1, 12'h01b, w, 65'h0);
        boot <= 1'b1;
        acc(0, 12'h01b, 0, {33'h0, w[31:11], 3'h1, 8'h0});
        $display("test base done");
        w = {$random(seed), 32'hffffffff};
        acc(1, 12'h010, w, 65'h0);
        acc(0, 12'h010, 0, {33'h0, 32'hffffffff});
        acc(0, 12'h010, 0, {1'b0, 64'h1_0000_0000});
        $display("test counter done");
        for (int i = 0; i < 8; i++) begin
            acc(0, 12'h017, 0, {12'h0, 3'(i), 50'h0});
            plat <= 3'(i);
        end
        acc(1, 12'h017, '1, 65'h0);
        acc(0, 12'h017, 0, {12'h0, 3'h7, 50'h0});
        w = {$random(seed), $random(seed)};
        mca <= w;
        acc(0, 12'h000, 0, {1'b0, w});
        w = {$random(seed), $random(seed)};
        mct <= w;
        acc(0, 12'h001, 0, {1'b0, w});
        acc(0, 12'h011, 0, {1'b1, 64'h0});
        acc(1, 12'hfff, '1, {1'b1, 64'h0});
        $display("test read-only and unmapped done");
        acc(1, 12'h02a, '1, 65'h0);
        acc(0, 12'h02a, 0, {63'h0, 2'h1});
        mgmt_n <= 1;
        init_n <= 0;
        rst;
        acc(0, 12'h02a, 0, {63'h0, 2'h2});
        rst;
        $display("test straps done");
        test_done;
    end
endmodule : test_model_specific_register_bank
`default_nettype wire
